/* File: src/fdcsr_field.sv */
// One configuration field with write strobe and soft-reset restore
`timescale 1ns/10ps
module fdcsr_field #(
   parameter int         W   = 8,
   parameter logic [7:0] RST = 8'h00
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Control
   input  wire logic         wr_en,
   input  wire logic         soft_rst,
   input  wire logic [W-1:0] wdata,
   // Stored value
   output logic      [W-1:0] q
);
   // Fields live in one byte lane
   if (W < 1 || W > 8) begin : g_bad_width
      $error("fdcsr_field width must be 1 to 8");
   end

   // Soft reset wins; the single register port cannot write both at once anyway
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= RST[W-1:0];
      end else if (soft_rst) begin
         q <= RST[W-1:0];
      end else if (wr_en) begin
         q <= wdata;
      end
   end
endmodule

/* File: src/fdcsr_pkg.sv */
// Register map, field layout, reset values and command codes of the fallback settings bank
package fdcsr_pkg;

   // Register port geometry
   localparam int         ADDR_W          = 6;
   localparam int         DATA_W          = 8;

   // Register offsets
   localparam logic [5:0] OFS_CUR2_LOW    = 6'h26;
   localparam logic [5:0] OFS_CUR2_HIGH   = 6'h27;
   localparam logic [5:0] OFS_PWM1_LOW    = 6'h28;
   localparam logic [5:0] OFS_PWM1_HIGH   = 6'h29;
   localparam logic [5:0] OFS_PWM2_LOW    = 6'h2A;
   localparam logic [5:0] OFS_PWM2_HIGH   = 6'h2B;
   localparam logic [5:0] OFS_TON1        = 6'h2C;
   localparam logic [5:0] OFS_TON2        = 6'h2D;
   localparam logic [5:0] OFS_RESET       = 6'h2E;

   // Field widths, all fields sit from bit 0 upward
   localparam int         CUR_LOW_W       = 2;
   localparam int         CUR_HIGH_W      = 8;
   localparam int         PWM_LOW_W       = 8;
   localparam int         PWM_HIGH_W      = 2;
   localparam int         TON_W           = 6;
   localparam int         CODE_W          = 10;

   // Reset values
   localparam logic [7:0] RST_CUR_LOW     = 8'h00;
   localparam logic [7:0] RST_CUR_HIGH    = 8'h00;
   localparam logic [7:0] RST_PWM_LOW     = 8'h00;
   localparam logic [7:0] RST_PWM_HIGH    = 8'h00;
   localparam logic [7:0] RST_TON         = 8'h07;
   localparam logic       RST_WDT_EN      = 1'b0;

   // Soft reset command codes
   localparam logic [7:0] CMD_RST_WDT_OFF = 8'hC3;
   localparam logic [7:0] CMD_RST_WDT_ON  = 8'hD4;

   // Value returned for reserved bits, unmapped and write-only addresses
   localparam logic [7:0] RD_ZERO         = 8'h00;

endpackage

/* File: src/fdcsr_rst_sync.sv */
// Reset synchroniser: asynchronous assertion, release through two flip-flops
`timescale 1ns/10ps
module fdcsr_rst_sync (
   // Clock and raw reset
   input  wire logic clk,
   input  wire logic nrst,
   // Released copy
   output logic      rst_n_sync
);
   logic stage_q;

   // Only the second stage is read, so release never sees a half-settled level
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stage_q    <= 1'b0;
         rst_n_sync <= 1'b0;
      end else begin
         stage_q    <= 1'b1;
         rst_n_sync <= stage_q;
      end
   end
endmodule

/* File: src/fdcsr_top.sv */
// Fallback dimming settings bank with soft reset command register
//
// How it works
// R1 - Channel 2 fallback current high byte is read/write, code bits 9 to 2.
// R2 - Channel 2 current low bits at 0x26 bits 1-0, high byte at 0x27.
// R3 - Channel 1 PWM width: low byte 0x28, top bits 0x29 bits 1-0, reset zero.
// R4 - Channel 2 PWM width: low byte 0x2A, top bits 0x2B bits 1-0, reset zero.
// R5 - PWM high registers bits 7-2 read zero and ignore writes.
// R6 - Channel 1 on-time is six bits, resets to 7 for 437 kHz.
// R7 - Channel 2 on-time is six bits, resets to 7, bits 7-6 read zero.
// R8 - Code 0xC3 restores all writable registers and turns the watchdog off.
// R9 - In stand-alone mode 0xC3 also sends both channel machines to load.
// R10 - Code 0xD4 restores all writable registers and turns the watchdog on.
// R11 - Stand-alone 0xD4 after timeout bits are cleared sends channel machines to detect.
// R12 - Reset command register is write-only and reads as zero.
// R13 - Soft reset leaves the power cycle flag untouched.
// R14 - Any other code written to the reset register does nothing.
`timescale 1ns/10ps
module fdcsr_top #(
   parameter int TMO_W = 2
) (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             nrst,
   // Register port from the serial framer, same clock
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   input  wire logic [5:0]       reg_addr,
   input  wire logic [7:0]       reg_wdata,
   output logic      [7:0]       reg_rdata,
   output logic                  reg_rvalid,
   // Device mode and status, same clock
   input  wire logic             stand_alone_mode,
   input  wire logic [TMO_W-1:0] comm_watchdog_timeout_bits,
   // Fallback settings
   output logic      [9:0]       fallback_current_ch2,
   output logic      [9:0]       fallback_pwm_width_ch1,
   output logic      [9:0]       fallback_pwm_width_ch2,
   output logic      [5:0]       fallback_on_time_ch1,
   output logic      [5:0]       fallback_on_time_ch2,
   // Watchdog and channel machine control
   output logic                  comm_wdt_enable,
   output logic                  sm_return_load,
   output logic                  sm_return_detect,
   output logic                  soft_reset_pulse
);

   // Elaboration checks
   if (TMO_W < 1 || TMO_W > 8) begin : g_bad_tmo
      $error("fdcsr_top timeout bit count must be 1 to 8");
   end

   logic                                  rst_n_sync;
   logic [fdcsr_pkg::CUR_LOW_W-1:0]       cur2_low_q;
   logic [fdcsr_pkg::CUR_HIGH_W-1:0]      cur2_high_q;
   logic [fdcsr_pkg::PWM_LOW_W-1:0]       pwm1_low_q;
   logic [fdcsr_pkg::PWM_HIGH_W-1:0]      pwm1_high_q;
   logic [fdcsr_pkg::PWM_LOW_W-1:0]       pwm2_low_q;
   logic [fdcsr_pkg::PWM_HIGH_W-1:0]      pwm2_high_q;
   logic [fdcsr_pkg::TON_W-1:0]           ton1_q;
   logic [fdcsr_pkg::TON_W-1:0]           ton2_q;
   logic                                  wr_cur2_low;
   logic                                  wr_cur2_high;
   logic                                  wr_pwm1_low;
   logic                                  wr_pwm1_high;
   logic                                  wr_pwm2_low;
   logic                                  wr_pwm2_high;
   logic                                  wr_ton1;
   logic                                  wr_ton2;
   logic                                  wr_reset;
   logic                                  cmd_wdt_off;
   logic                                  cmd_wdt_on;
   logic                                  soft_rst;
   logic                                  tmo_clear;
   logic [7:0]                            rd_mux;
   logic                                  wdt_en_q;
   logic                                  load_q;
   logic                                  detect_q;
   logic                                  srst_q;
   logic [7:0]                            rdata_q;
   logic                                  rvalid_q;

   // Reset release
   fdcsr_rst_sync u_rst_sync (
      .clk        (sys_clk),
      .nrst       (nrst),
      .rst_n_sync (rst_n_sync)
   );

   // Address decode of writes
   assign wr_cur2_low  = reg_wr && (reg_addr == fdcsr_pkg::OFS_CUR2_LOW);   // [R2]
   assign wr_cur2_high = reg_wr && (reg_addr == fdcsr_pkg::OFS_CUR2_HIGH);  // [R1] [R2]
   assign wr_pwm1_low  = reg_wr && (reg_addr == fdcsr_pkg::OFS_PWM1_LOW);   // [R3]
   assign wr_pwm1_high = reg_wr && (reg_addr == fdcsr_pkg::OFS_PWM1_HIGH);  // [R3]
   assign wr_pwm2_low  = reg_wr && (reg_addr == fdcsr_pkg::OFS_PWM2_LOW);   // [R4]
   assign wr_pwm2_high = reg_wr && (reg_addr == fdcsr_pkg::OFS_PWM2_HIGH);  // [R4]
   assign wr_ton1      = reg_wr && (reg_addr == fdcsr_pkg::OFS_TON1);       // [R6]
   assign wr_ton2      = reg_wr && (reg_addr == fdcsr_pkg::OFS_TON2);       // [R7]
   assign wr_reset     = reg_wr && (reg_addr == fdcsr_pkg::OFS_RESET);

   // Command decode; unknown codes match neither and fall through
   assign cmd_wdt_off = wr_reset && (reg_wdata == fdcsr_pkg::CMD_RST_WDT_OFF);  // [R8] [R14]
   assign cmd_wdt_on  = wr_reset && (reg_wdata == fdcsr_pkg::CMD_RST_WDT_ON);   // [R10] [R14]
   assign soft_rst    = cmd_wdt_off || cmd_wdt_on;
   assign tmo_clear   = ~|comm_watchdog_timeout_bits;

   // Channel 2 fallback current code
   fdcsr_field #(.W(fdcsr_pkg::CUR_LOW_W), .RST(fdcsr_pkg::RST_CUR_LOW)) u_cur2_low (
      .clk      (sys_clk),
      .rst_n    (rst_n_sync),
      .wr_en    (wr_cur2_low),
      .soft_rst (soft_rst),
      .wdata    (reg_wdata[fdcsr_pkg::CUR_LOW_W-1:0]),
      .q        (cur2_low_q)
   );
   fdcsr_field #(.W(fdcsr_pkg::CUR_HIGH_W), .RST(fdcsr_pkg::RST_CUR_HIGH)) u_cur2_high (
      .clk      (sys_clk),
      .rst_n    (rst_n_sync),
      .wr_en    (wr_cur2_high),
      .soft_rst (soft_rst),
      .wdata    (reg_wdata[fdcsr_pkg::CUR_HIGH_W-1:0]),
      .q        (cur2_high_q)
   );

   // Channel 1 fallback PWM width; high part keeps only bits 1-0
   fdcsr_field #(.W(fdcsr_pkg::PWM_LOW_W), .RST(fdcsr_pkg::RST_PWM_LOW)) u_pwm1_low (
      .clk      (sys_clk),
      .rst_n    (rst_n_sync),
      .wr_en    (wr_pwm1_low),
      .soft_rst (soft_rst),
      .wdata    (reg_wdata[fdcsr_pkg::PWM_LOW_W-1:0]),
      .q        (pwm1_low_q)
   );
   fdcsr_field #(.W(fdcsr_pkg::PWM_HIGH_W), .RST(fdcsr_pkg::RST_PWM_HIGH)) u_pwm1_high (
      .clk      (sys_clk),
      .rst_n    (rst_n_sync),
      .wr_en    (wr_pwm1_high),
      .soft_rst (soft_rst),
      .wdata    (reg_wdata[fdcsr_pkg::PWM_HIGH_W-1:0]),
      .q        (pwm1_high_q)
   );

   // Channel 2 fallback PWM width
   fdcsr_field #(.W(fdcsr_pkg::PWM_LOW_W), .RST(fdcsr_pkg::RST_PWM_LOW)) u_pwm2_low (
      .clk      (sys_clk),
      .rst_n    (rst_n_sync),
      .wr_en    (wr_pwm2_low),
      .soft_rst (soft_rst),
      .wdata    (reg_wdata[fdcsr_pkg::PWM_LOW_W-1:0]),
      .q        (pwm2_low_q)
   );
   fdcsr_field #(.W(fdcsr_pkg::PWM_HIGH_W), .RST(fdcsr_pkg::RST_PWM_HIGH)) u_pwm2_high (
      .clk      (sys_clk),
      .rst_n    (rst_n_sync),
      .wr_en    (wr_pwm2_high),
      .soft_rst (soft_rst),
      .wdata    (reg_wdata[fdcsr_pkg::PWM_HIGH_W-1:0]),
      .q        (pwm2_high_q)
   );

   // Fallback on-time of both channels, default gives 437 kHz
   fdcsr_field #(.W(fdcsr_pkg::TON_W), .RST(fdcsr_pkg::RST_TON)) u_ton1 (
      .clk      (sys_clk),
      .rst_n    (rst_n_sync),
      .wr_en    (wr_ton1),
      .soft_rst (soft_rst),
      .wdata    (reg_wdata[fdcsr_pkg::TON_W-1:0]),
      .q        (ton1_q)
   );
   fdcsr_field #(.W(fdcsr_pkg::TON_W), .RST(fdcsr_pkg::RST_TON)) u_ton2 (
      .clk      (sys_clk),
      .rst_n    (rst_n_sync),
      .wr_en    (wr_ton2),
      .soft_rst (soft_rst),
      .wdata    (reg_wdata[fdcsr_pkg::TON_W-1:0]),
      .q        (ton2_q)
   );

   // Watchdog enable follows the last valid command only
   always_ff @(posedge sys_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         wdt_en_q <= fdcsr_pkg::RST_WDT_EN;
      end else if (cmd_wdt_off) begin
         wdt_en_q <= 1'b0;  // [R8]
      end else if (cmd_wdt_on) begin
         wdt_en_q <= 1'b1;  // [R10]
      end
   end

   // Channel machine requests; detect is raised only if the timeout bits are already clear, never later
   always_ff @(posedge sys_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         load_q   <= 1'b0;
         detect_q <= 1'b0;
      end else begin
         load_q   <= cmd_wdt_off && stand_alone_mode;             // [R9]
         detect_q <= cmd_wdt_on && stand_alone_mode && tmo_clear; // [R11]
      end
   end

   // Soft reset strobe to the rest of the device; status bits are not in its reach
   always_ff @(posedge sys_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         srst_q <= 1'b0;
      end else begin
         srst_q <= soft_rst;  // [R13]
      end
   end

   // Read multiplexer; reserved bits and the command register read zero
   always_comb begin
      rd_mux = fdcsr_pkg::RD_ZERO;
      case (reg_addr)
         fdcsr_pkg::OFS_CUR2_LOW: begin
            rd_mux[fdcsr_pkg::CUR_LOW_W-1:0] = cur2_low_q;    // [R2]
         end
         fdcsr_pkg::OFS_CUR2_HIGH: begin
            rd_mux = cur2_high_q;                             // [R1]
         end
         fdcsr_pkg::OFS_PWM1_LOW: begin
            rd_mux = pwm1_low_q;                              // [R3]
         end
         fdcsr_pkg::OFS_PWM1_HIGH: begin
            rd_mux[fdcsr_pkg::PWM_HIGH_W-1:0] = pwm1_high_q;  // [R5]
         end
         fdcsr_pkg::OFS_PWM2_LOW: begin
            rd_mux = pwm2_low_q;                              // [R4]
         end
         fdcsr_pkg::OFS_PWM2_HIGH: begin
            rd_mux[fdcsr_pkg::PWM_HIGH_W-1:0] = pwm2_high_q;  // [R5]
         end
         fdcsr_pkg::OFS_TON1: begin
            rd_mux[fdcsr_pkg::TON_W-1:0] = ton1_q;            // [R6]
         end
         fdcsr_pkg::OFS_TON2: begin
            rd_mux[fdcsr_pkg::TON_W-1:0] = ton2_q;            // [R7]
         end
         fdcsr_pkg::OFS_RESET: begin
            rd_mux = fdcsr_pkg::RD_ZERO;                      // [R12]
         end
         default: begin
            rd_mux = fdcsr_pkg::RD_ZERO;
         end
      endcase
   end

   // Read data is captured so the framer sees a flop; it holds until the next read
   always_ff @(posedge sys_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         rdata_q  <= fdcsr_pkg::RD_ZERO;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= reg_rd;
         if (reg_rd) begin
            rdata_q <= rd_mux;
         end
      end
   end

   // Outputs, all taken from flops
   assign fallback_current_ch2   = {cur2_high_q, cur2_low_q};  // [R1]
   assign fallback_pwm_width_ch1 = {pwm1_high_q, pwm1_low_q};
   assign fallback_pwm_width_ch2 = {pwm2_high_q, pwm2_low_q};
   assign fallback_on_time_ch1   = ton1_q;
   assign fallback_on_time_ch2   = ton2_q;
   assign comm_wdt_enable        = wdt_en_q;
   assign sm_return_load         = load_q;
   assign sm_return_detect       = detect_q;
   assign soft_reset_pulse       = srst_q;
   assign reg_rdata              = rdata_q;
   assign reg_rvalid             = rvalid_q;

   // Checks on the bank's own behaviour
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n_sync);

   sequence s_cmd_off;
      reg_wr && reg_addr == fdcsr_pkg::OFS_RESET && reg_wdata == fdcsr_pkg::CMD_RST_WDT_OFF;
   endsequence

   sequence s_cmd_on;
      reg_wr && reg_addr == fdcsr_pkg::OFS_RESET && reg_wdata == fdcsr_pkg::CMD_RST_WDT_ON;
   endsequence

   sequence s_cmd_other;
      reg_wr && reg_addr == fdcsr_pkg::OFS_RESET && reg_wdata != fdcsr_pkg::CMD_RST_WDT_OFF
         && reg_wdata != fdcsr_pkg::CMD_RST_WDT_ON;
   endsequence

   a_cur2_high_write: assert property (reg_wr && reg_addr == fdcsr_pkg::OFS_CUR2_HIGH |=> // [R1]
      fallback_current_ch2[9:2] == $past(reg_wdata))
      else $error("Current high byte not stored");

   a_cur2_low_write: assert property (reg_wr && reg_addr == fdcsr_pkg::OFS_CUR2_LOW |=> // [R2]
      fallback_current_ch2[1:0] == $past(reg_wdata[1:0]) && $stable(fallback_current_ch2[9:2]))
      else $error("Current low bits not stored");

   a_pwm1_high_write: assert property (reg_wr && reg_addr == fdcsr_pkg::OFS_PWM1_HIGH |=> // [R3]
      fallback_pwm_width_ch1 == {$past(reg_wdata[1:0]), $past(fallback_pwm_width_ch1[7:0])})
      else $error("Channel 1 PWM top bits not stored");

   a_pwm2_low_write: assert property (reg_wr && reg_addr == fdcsr_pkg::OFS_PWM2_LOW |=> // [R4]
      fallback_pwm_width_ch2 == {$past(fallback_pwm_width_ch2[9:8]), $past(reg_wdata)})
      else $error("Channel 2 PWM low byte not stored");

   a_pwm_reserved_zero: assert property (reg_rd && (reg_addr == fdcsr_pkg::OFS_PWM1_HIGH || // [R5]
      reg_addr == fdcsr_pkg::OFS_PWM2_HIGH) |=> reg_rvalid && reg_rdata[7:2] == 6'h00)
      else $error("PWM high reserved bits not zero");

   a_ton_restore_off: assert property (s_cmd_off |=> fallback_on_time_ch1 == 6'h07 && // [R6]
      fallback_on_time_ch2 == 6'h07 && fallback_pwm_width_ch1 == 10'h000)
      else $error("Command C3 did not restore defaults");

   a_ton2_read_back: assert property (reg_rd && reg_addr == fdcsr_pkg::OFS_TON2 |=> // [R7]
      reg_rdata == {2'h0, $past(fallback_on_time_ch2)}) // Same-cycle write lands after the read
      else $error("Channel 2 on-time read back wrong");

   a_wdt_off_cmd: assert property (s_cmd_off |=> !comm_wdt_enable && soft_reset_pulse ##1 // [R8]
      soft_reset_pulse == $past(soft_rst)) // Stays up only for a back-to-back command
      else $error("Command C3 did not disable watchdog");

   a_load_return: assert property (s_cmd_off |=> sm_return_load == $past(stand_alone_mode) // [R9]
      && !sm_return_detect)
      else $error("Load return wrong after C3");

   a_wdt_on_cmd: assert property (s_cmd_on |=> comm_wdt_enable && fallback_current_ch2 == 10'h000 // [R10]
      && fallback_on_time_ch1 == 6'h07)
      else $error("Command D4 did not restore and enable watchdog");

   a_detect_return: assert property (s_cmd_on |=> sm_return_detect == // [R11]
      ($past(stand_alone_mode) && $past(comm_watchdog_timeout_bits) == '0) && !sm_return_load)
      else $error("Detect return wrong after D4");

   a_reset_reads_zero: assert property (reg_rd && reg_addr == fdcsr_pkg::OFS_RESET |=> // [R12]
      reg_rvalid && reg_rdata == 8'h00)
      else $error("Reset register read not zero");

   a_other_code_noop: assert property (s_cmd_other |=> $stable(comm_wdt_enable) && // [R14]
      !soft_reset_pulse && !sm_return_load && !sm_return_detect && $stable(fallback_on_time_ch1))
      else $error("Undefined reset code had an effect");

endmodule

/* File: testbench/fdcsr_status_model.sv */
// Host-side status model: stand-alone mode and watchdog timeout bits
`timescale 1ns/10ps
module fdcsr_status_model #(
   parameter int TMO_W = 2
) (
   // Clock
   input  wire logic             clk,
   // Host requests
   input  wire logic             mode_req,
   input  wire logic             trip,
   input  wire logic             status_rd,
   // Status seen by the bank
   output logic                  stand_alone_mode,
   output logic      [TMO_W-1:0] tmo_bits
);
   // Mode follows the host request one cycle late
   always @(posedge clk) begin
      stand_alone_mode <= mode_req;
   end

   // Timeout bits latch on a trip; only a status read clears them
   always @(posedge clk) begin
      if (status_rd) begin
         tmo_bits <= '0;
      end else if (trip) begin
         tmo_bits <= {TMO_W{1'b1}};
      end
   end
endmodule

/* File: testbench/testbench.sv */
// Self-checking bench for the fallback settings bank
`timescale 1ns/10ps
module testbench;
   // Design and partner connections
   logic       sys_clk, nrst, reg_wr, reg_rd, reg_rvalid;
   logic [5:0] reg_addr, fallback_on_time_ch1, fallback_on_time_ch2;
   logic [7:0] reg_wdata, reg_rdata;
   logic [9:0] fallback_current_ch2, fallback_pwm_width_ch1, fallback_pwm_width_ch2;
   logic       comm_wdt_enable, sm_return_load, sm_return_detect, soft_reset_pulse;
   logic       mode_req, trip, status_rd, stand_alone_mode;
   logic [1:0] tmo_bits;
   // Reference model: stored bytes for 0x26..0x2E, masks, defaults
   int         m[9];
   int         mk[9] = '{3, 255, 255, 3, 255, 3, 63, 63, 0};
   int         df[9] = '{0, 0, 0, 0, 0, 0, 7, 7, 0};
   int         wdt, bad_count, cmp_count, seed;
   logic [7:0] cmd[4] = '{8'hC3, 8'hD4, 8'hA5, 8'h00};

   fdcsr_top #(.TMO_W(2)) i_fdcsr_top (.sys_clk, .nrst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
      .reg_rdata, .reg_rvalid, .stand_alone_mode, .comm_watchdog_timeout_bits(tmo_bits),
      .fallback_current_ch2, .fallback_pwm_width_ch1, .fallback_pwm_width_ch2, .fallback_on_time_ch1,
      .fallback_on_time_ch2, .comm_wdt_enable, .sm_return_load, .sm_return_detect, .soft_reset_pulse);

   fdcsr_status_model #(.TMO_W(2)) i_fdcsr_status_model (.clk(sys_clk), .mode_req, .trip, .status_rd,
      .stand_alone_mode, .tmo_bits);

   // 40 MHz clock
   always #12.5 sys_clk = ~sys_clk;

   // Verdict and end of run
   task close_out;
      if (bad_count == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // Compare one value
   task automatic chk(logic [15:0] s, logic [15:0] e);
      cmp_count++;
      if (s !== e) begin
         bad_count++;
         $display("mismatch at %0t seen %h expected %h", $time, s, e);
      end
   endtask

   // One port cycle from a falling edge; outputs checked at the next falling edge, read data only on reads
   task automatic op(logic w, logic r, logic [5:0] a, logic [7:0] d);
      int         i;
      logic [7:0] rexp;
      logic       ld, dt, sp;
      i = int'(a) - 38;
      rexp = (i >= 0 && i < 9) ? 8'(m[i]) : 8'h00; // Read sees the old value
      ld = 0;
      dt = 0;
      sp = 0;
      reg_wr = w;
      reg_rd = r;
      reg_addr = a;
      reg_wdata = d;
      if (w && i == 8 && (d == 8'hC3 || d == 8'hD4)) begin
         foreach (m[k]) m[k] = df[k];
         wdt = (d == 8'hD4);
         sp = 1;
         ld = (d == 8'hC3) && stand_alone_mode;
         dt = (d == 8'hD4) && stand_alone_mode && (tmo_bits == 2'b00);
      end else if (w && i >= 0 && i < 8) begin
         m[i] = d & mk[i];
      end
      @(negedge sys_clk);
      if (r) chk(reg_rdata, rexp);
      chk(reg_rvalid, r);
      chk(fallback_current_ch2, {m[1][7:0], m[0][1:0]});
      chk(fallback_pwm_width_ch1, {m[3][1:0], m[2][7:0]});
      chk(fallback_pwm_width_ch2, {m[5][1:0], m[4][7:0]});
      chk(fallback_on_time_ch1, m[6][5:0]);
      chk(fallback_on_time_ch2, m[7][5:0]);
      chk(comm_wdt_enable, wdt[0]);
      chk(soft_reset_pulse, sp);
      chk(sm_return_load, ld);
      chk(sm_return_detect, dt);
   endtask

   // Host sets mode and, in the same cycle, trips or clears the timeout bits by a status read
   task automatic ctl(logic sa, logic tr);
      mode_req = sa;
      trip = tr;
      status_rd = !tr;
      op(0, 0, 6'h00, 8'h00);
      trip = 0;
      status_rd = 0;
      op(0, 0, 6'h00, 8'h00);
   endtask

   // Main sequence
   initial begin
      sys_clk = 0;
      nrst = 0;
      {reg_wr, reg_rd, reg_addr, reg_wdata, mode_req, trip} = '0;
      status_rd = 1; // Timeout bits start known, cleared while reset is held
      seed = 34516;
      wdt = 0;
      foreach (m[k]) m[k] = df[k];
      repeat (10) @(negedge sys_clk);
      nrst = 1;
      status_rd = 0;
      repeat (3) @(negedge sys_clk);
      // Power-on values, unmapped and write-only reads
      for (int a = 36; a < 48; a++) op(0, 1, 6'(a), 8'h00);
      // Random traffic, writes and reads overlapping, mode and trips varied
      for (int n = 0; n < 300; n++) begin
         if (n % 40 == 0) ctl(1'($random(seed)), 1'($random(seed)));
         op(1'($random(seed)), 1'($random(seed)), 6'(36 + ($random(seed) & 15)), 8'($random(seed)));
      end
      // Codes C3, D4, A5 and 00 in every mode and timeout state, bank filled first
      foreach (cmd[c]) begin
         for (int s = 0; s < 4; s++) begin
            ctl(s[0], s[1]);
            for (int a = 38; a < 46; a++) op(1, 0, 6'(a), 8'hFF);
            op(1, 1, 6'h2E, cmd[c]);
            op(0, 0, 6'h00, 8'h00);
         end
      end
      // Back-to-back commands
      op(1, 0, 6'h2E, 8'hC3);
      op(1, 0, 6'h2E, 8'hD4);
      op(0, 0, 6'h00, 8'h00);
      close_out();
   end

   // Hang guard, far beyond the few hundred cycles the run needs
   initial begin
      #200000;
      bad_count++;
      close_out();
   end
endmodule
